// file: charger_pmic_status_control_regs.sv
// fault, status, control and user configuration register bank
`default_nettype none
module charger_pmic_status_control_regs #(
  parameter int IRQ_CYC = charger_regs_pkg::IRQ_CYC
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OEN,
  output logic O_IRQ,
  output logic O_IRQ_OEN,
  input wire logic I_PRECHARGE_TIMEOUT_FAULT,
  input wire logic I_CHARGE_TIMEOUT_FAULT,
  input wire logic I_DOG_TIMEOUT_FAULT,
  input wire logic I_DOG_COUNT_WRITE,
  input wire logic I_INPUT_OVERCURRENT_FAULT,
  input wire logic I_INPUT_OVERVOLTAGE_FAULT,
  input wire logic I_RIGHT_BUD_UNDERVOLTAGE_FAULT,
  input wire logic I_LEFT_BUD_UNDERVOLTAGE_FAULT,
  input wire logic I_SYS_RAIL_OVERVOLTAGE_FAULT,
  input wire logic I_SYS_RAIL_UNDERVOLTAGE_FAULT,
  input wire logic I_THERMISTOR_HOT_FAULT,
  input wire logic I_THERMISTOR_COLD_FAULT,
  input wire logic I_BATTERY_OVERVOLTAGE_FAULT,
  input wire logic I_BATTERY_UNDERVOLTAGE_FAULT,
  input wire logic I_OVER_TEMPERATURE_FAULT,
  input wire logic I_PRECHARGE_ON_FLAG,
  input wire logic I_INPUT_SUPPLY_ON_FLAG,
  input wire logic I_INPUT_OV_DETECT_ON_FLAG,
  input wire logic I_BELOW_PRECHARGE_LEVEL_FLAG,
  input wire logic I_BELOW_RECHARGE_LEVEL_FLAG,
  input wire logic I_LEFT_SWITCH_ON_FLAG,
  input wire logic I_RIGHT_SWITCH_ON_FLAG,
  input wire logic I_INPUT_ATTACHED_FLAG,
  input wire logic I_CHARGE_DONE_FLAG,
  input wire logic I_CC_PHASE_DONE_FLAG,
  input wire logic I_LEFT_BUD_PRESENT_FLAG,
  input wire logic I_RIGHT_BUD_PRESENT_FLAG,
  input wire logic I_LEFT_LIGHT_LOAD_FLAG,
  input wire logic I_RIGHT_LIGHT_LOAD_FLAG,
  input wire logic I_BOOST_ON_FLAG,
  input wire logic I_LEFT_UV_DETECT_ON_FLAG,
  input wire logic I_RIGHT_UV_DETECT_ON_FLAG,
  input wire logic I_RECHARGE_COMPARATOR_ON_FLAG,
  input wire logic I_BATTERY_OV_DETECT_ON_FLAG,
  input wire logic I_PRECHARGE_COMPARATOR_ON_FLAG,
  input wire logic I_CHARGING_ON_FLAG,
  output logic O_THERMAL_REGULATION_OFF,
  output logic O_DOG_FEED,
  output logic O_CONVERTER_ON,
  output logic [1:0] O_CONVERTER_CLOCK_SELECT,
  output logic O_CHIP_RESET,
  output logic O_BOOST_ON,
  output logic O_CHARGING_ON,
  output logic O_LEFT_SWITCH_ON,
  output logic O_RIGHT_SWITCH_ON,
  output logic O_SLEEP_ON,
  output logic [1:0] O_INDICATOR_DRIVE_CURRENT,
  output logic [1:0] O_BOOST_CURRENT_THRESHOLD,
  output logic [1:0] O_LIGHT_LOAD_TRIM,
  output logic [2:0] O_BOOST_VOLTAGE_SELECT,
  output logic [1:0] O_INPUT_LIMIT_TRIM,
  output logic [1:0] O_PRECHARGE_CURRENT_SELECT,
  output logic [1:0] O_PRECHARGE_END_VOLTAGE,
  output logic [1:0] O_CC_CURRENT_SCALE,
  output logic [1:0] O_RECHARGE_THRESHOLD_SELECT
);
  logic [1:0] rst_pipe;
  logic rst_n;
  logic bus_wr, bus_nack, regs_clr, rst_all_reg, rst_oth_reg;
  logic [4:0] bus_addr;
  logic [15:0] bus_wdata, rd_data;
  logic [15:0] fault_reg, fault_next, fault_hw, fault_clr;
  logic [15:0] st1_now, st1_reg, st2_now, st2_reg;
  logic [15:0] ctrl_reg, ucfg1_reg, ucfg2_reg;
  logic feed_reg, clr_all_reg, wr_ctrl, wr_fault, dog_clr, irq_event;
  logic [charger_regs_pkg::IRQ_CNT_W-1:0] irq_cnt;

  // reset is released through two flops; async assert, sync release
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  serial_frame_slave bus_if (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_bus_rst(rst_all_reg),
    .i_scl(I_SCL),
    .i_sda(I_SDA),
    .o_sda_oen(O_SDA_OEN),
    .o_wr(bus_wr),
    .o_addr(bus_addr),
    .o_wdata(bus_wdata),
    .i_rdata(rd_data),
    .o_nack(bus_nack)
  );
  assign O_SDA = 1'b0;
  assign O_IRQ = 1'b0;

  assign wr_ctrl = bus_wr && bus_addr == charger_regs_pkg::ADR_CTRL;
  assign wr_fault = bus_wr && bus_addr == charger_regs_pkg::ADR_FAULT;
  // the soft reset lands one cycle after the write that asked for it
  assign regs_clr = rst_all_reg | rst_oth_reg;

  // clear and reset bits are stored nowhere: each write of one is one pulse
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      clr_all_reg <= 1'b0;
      rst_all_reg <= 1'b0;
      rst_oth_reg <= 1'b0;
      O_CHIP_RESET <= 1'b0;
    end else begin
      clr_all_reg <= wr_ctrl && bus_wdata[charger_regs_pkg::CB_CLRALL];
      rst_all_reg <= wr_ctrl && bus_wdata[charger_regs_pkg::CB_RSTALL];
      rst_oth_reg <= wr_ctrl && bus_wdata[charger_regs_pkg::CB_RSTOTH];
      O_CHIP_RESET <= wr_ctrl &&
                      (bus_wdata[charger_regs_pkg::CB_RSTALL] ||
                       bus_wdata[charger_regs_pkg::CB_RSTOTH]);
    end
  end

  assign dog_clr = (wr_ctrl && bus_wdata[charger_regs_pkg::CB_FEED]) ||
                   I_DOG_COUNT_WRITE;

  assign fault_hw = {bus_nack, 1'b0, I_PRECHARGE_TIMEOUT_FAULT,
                     I_CHARGE_TIMEOUT_FAULT, I_DOG_TIMEOUT_FAULT,
                     I_INPUT_OVERCURRENT_FAULT, I_INPUT_OVERVOLTAGE_FAULT,
                     I_RIGHT_BUD_UNDERVOLTAGE_FAULT,
                     I_LEFT_BUD_UNDERVOLTAGE_FAULT,
                     I_SYS_RAIL_OVERVOLTAGE_FAULT,
                     I_SYS_RAIL_UNDERVOLTAGE_FAULT,
                     I_THERMISTOR_HOT_FAULT, I_THERMISTOR_COLD_FAULT,
                     I_BATTERY_OVERVOLTAGE_FAULT,
                     I_BATTERY_UNDERVOLTAGE_FAULT,
                     I_OVER_TEMPERATURE_FAULT};

  always_comb begin
    fault_clr = 16'h0000;
    if (clr_all_reg) begin
      fault_clr = charger_regs_pkg::FAULT_CLR_ALL_MASK;
    end
    fault_clr[charger_regs_pkg::FB_DOG] = dog_clr;
    fault_clr[charger_regs_pkg::FB_ACK] =
      wr_fault && bus_wdata[charger_regs_pkg::FB_ACK];
    // a new event in the clearing cycle survives the clear
    fault_next = ((fault_reg & ~fault_clr) | fault_hw) &
                 charger_regs_pkg::FAULT_USED_MASK;
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      fault_reg <= charger_regs_pkg::FAULT_RST;
    end else if (regs_clr) begin
      fault_reg <= charger_regs_pkg::FAULT_RST;
    end else begin
      fault_reg <= fault_next;
    end
  end

  assign st1_now = {I_PRECHARGE_ON_FLAG, I_INPUT_SUPPLY_ON_FLAG,
                    I_INPUT_OV_DETECT_ON_FLAG, I_BELOW_PRECHARGE_LEVEL_FLAG,
                    I_BELOW_RECHARGE_LEVEL_FLAG, I_LEFT_SWITCH_ON_FLAG,
                    I_RIGHT_SWITCH_ON_FLAG, 1'b0, I_INPUT_ATTACHED_FLAG,
                    I_CHARGE_DONE_FLAG, I_CC_PHASE_DONE_FLAG,
                    I_LEFT_BUD_PRESENT_FLAG, I_RIGHT_BUD_PRESENT_FLAG,
                    I_LEFT_LIGHT_LOAD_FLAG, I_RIGHT_LIGHT_LOAD_FLAG,
                    I_BOOST_ON_FLAG};
  assign st2_now = {8'h00, I_LEFT_UV_DETECT_ON_FLAG,
                    I_RIGHT_UV_DETECT_ON_FLAG, I_RECHARGE_COMPARATOR_ON_FLAG,
                    I_BATTERY_OV_DETECT_ON_FLAG, 2'b00,
                    I_PRECHARGE_COMPARATOR_ON_FLAG,
                    I_CHARGING_ON_FLAG};

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st1_reg <= 16'h0000;
      st2_reg <= 16'h0000;
    end else begin
      st1_reg <= st1_now;
      st2_reg <= st2_now;
    end
  end

  // control: plain bits stored, feed bit toggles on each write of one and clears on a dog count write
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= charger_regs_pkg::CTRL_RST;
      feed_reg <= 1'b0;
      O_DOG_FEED <= 1'b0;
    end else if (regs_clr) begin
      ctrl_reg <= charger_regs_pkg::CTRL_RST;
      feed_reg <= 1'b0;
      O_DOG_FEED <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= bus_wdata & charger_regs_pkg::CTRL_KEEP_MASK;
      end
      if (I_DOG_COUNT_WRITE) begin
        feed_reg <= 1'b0;
      end else if (wr_ctrl && bus_wdata[charger_regs_pkg::CB_FEED]) begin
        feed_reg <= ~feed_reg;
      end
      O_DOG_FEED <= wr_ctrl && bus_wdata[charger_regs_pkg::CB_FEED] &&
                    !feed_reg && !I_DOG_COUNT_WRITE;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ucfg1_reg <= charger_regs_pkg::UCFG1_RST;
      ucfg2_reg <= charger_regs_pkg::UCFG2_RST;
    end else if (regs_clr) begin
      ucfg1_reg <= charger_regs_pkg::UCFG1_RST;
      ucfg2_reg <= charger_regs_pkg::UCFG2_RST;
    end else if (bus_wr) begin
      if (bus_addr == charger_regs_pkg::ADR_UCFG1) begin
        ucfg1_reg <= bus_wdata & charger_regs_pkg::UCFG1_MASK;
      end
      if (bus_addr == charger_regs_pkg::ADR_UCFG2) begin
        ucfg2_reg <= bus_wdata & charger_regs_pkg::UCFG2_MASK;
      end
    end
  end

  assign O_THERMAL_REGULATION_OFF = ctrl_reg[charger_regs_pkg::CB_THERM];
  assign O_CONVERTER_ON = ctrl_reg[charger_regs_pkg::CB_CONV];
  assign O_CONVERTER_CLOCK_SELECT =
    ctrl_reg[charger_regs_pkg::CB_CLK +: 2];
  assign O_BOOST_ON = ctrl_reg[charger_regs_pkg::CB_BOOST];
  assign O_CHARGING_ON = ctrl_reg[charger_regs_pkg::CB_CHG];
  assign O_LEFT_SWITCH_ON = ctrl_reg[charger_regs_pkg::CB_LSW];
  assign O_RIGHT_SWITCH_ON = ctrl_reg[charger_regs_pkg::CB_RSW];
  assign O_SLEEP_ON = ctrl_reg[charger_regs_pkg::CB_SLEEP];
  assign O_INDICATOR_DRIVE_CURRENT = ucfg1_reg[charger_regs_pkg::U1_LED +: 2];
  assign O_BOOST_CURRENT_THRESHOLD =
    ucfg1_reg[charger_regs_pkg::U1_BOOST +: 2];
  assign O_LIGHT_LOAD_TRIM = ucfg1_reg[charger_regs_pkg::U1_TRIM +: 2];
  assign O_BOOST_VOLTAGE_SELECT = ucfg2_reg[charger_regs_pkg::U2_VOUT +: 3];
  assign O_INPUT_LIMIT_TRIM = ucfg2_reg[charger_regs_pkg::U2_INLIM +: 2];
  // code 11 is passed on as is; the analog side treats it as 150%
  assign O_PRECHARGE_CURRENT_SELECT =
    ucfg2_reg[charger_regs_pkg::U2_PCHI +: 2];
  assign O_PRECHARGE_END_VOLTAGE =
    ucfg2_reg[charger_regs_pkg::U2_PCHV +: 2];
  assign O_CC_CURRENT_SCALE = ucfg2_reg[charger_regs_pkg::U2_CC +: 2];
  assign O_RECHARGE_THRESHOLD_SELECT =
    ucfg2_reg[charger_regs_pkg::U2_RCH +: 2];

  always_comb begin
    rd_data = 16'h0000;
    unique case (bus_addr)
      charger_regs_pkg::ADR_FAULT: rd_data = fault_reg;
      charger_regs_pkg::ADR_STAT1: rd_data = st1_reg;
      charger_regs_pkg::ADR_STAT2: rd_data = st2_reg;
      charger_regs_pkg::ADR_CTRL: begin
        rd_data = ctrl_reg;
        rd_data[charger_regs_pkg::CB_FEED] = feed_reg;
      end
      charger_regs_pkg::ADR_UCFG1: rd_data = ucfg1_reg;
      charger_regs_pkg::ADR_UCFG2: rd_data = ucfg2_reg;
      default: rd_data = 16'h0000;
    endcase
  end

  // a retriggering event restarts the full low time
  assign irq_event = |(fault_hw & ~fault_reg &
                       charger_regs_pkg::FAULT_USED_MASK) ||
                     |((st1_now ^ st1_reg) & charger_regs_pkg::ST1_EVT_MASK);

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_cnt <= '0;
    end else if (irq_event) begin
      irq_cnt <= charger_regs_pkg::IRQ_CNT_W'(IRQ_CYC);
    end else if (irq_cnt != '0) begin
      irq_cnt <= irq_cnt - 1'b1;
    end
  end
  assign O_IRQ_OEN = (irq_cnt == '0);

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!rst_n);

  a_ack_set: assert property (
    bus_nack && !regs_clr |=> fault_reg[charger_regs_pkg::FB_ACK])
    else $error("ack fault not raised");
  a_ack_clear: assert property (
    wr_fault && bus_wdata[charger_regs_pkg::FB_ACK] && !bus_nack &&
    !regs_clr |=> !fault_reg[charger_regs_pkg::FB_ACK])
    else $error("ack fault not cleared");
  a_clear_all_faults: assert property (
    wr_ctrl && bus_wdata[charger_regs_pkg::CB_CLRALL] ##1
    !(|(fault_hw & charger_regs_pkg::FAULT_CLR_ALL_MASK)) |=>
    (fault_reg & charger_regs_pkg::FAULT_CLR_ALL_MASK) == 16'h0000)
    else $error("clear all left a flag set");
  a_dog_fault_clear: assert property (
    I_DOG_COUNT_WRITE && !I_DOG_TIMEOUT_FAULT |=>
    !fault_reg[charger_regs_pkg::FB_DOG] && !feed_reg)
    else $error("watchdog fault or feed not cleared");
  a_hw_fault_sticky: assert property (
    fault_reg[charger_regs_pkg::FB_OC] && !regs_clr
    |=> fault_reg[charger_regs_pkg::FB_OC])
    else $error("overcurrent flag dropped");
  a_reserved_zero: assert property (
    (fault_reg & ~charger_regs_pkg::FAULT_USED_MASK) == 16'h0000 &&
    (ctrl_reg & ~charger_regs_pkg::CTRL_KEEP_MASK) == 16'h0000 &&
    st1_reg[8] == 1'b0 && st2_reg[15:8] == 8'h00 && st2_reg[3:2] == 2'b00)
    else $error("reserved bit reads one");
  a_status_follow: assert property (
    ##1 st1_reg == $past(st1_now) && st1_reg[8] == 1'b0)
    else $error("status does not follow inputs");
  a_thermal_polarity: assert property (
    wr_ctrl && !regs_clr |=>
    O_THERMAL_REGULATION_OFF == $past(bus_wdata[charger_regs_pkg::CB_THERM]))
    else $error("thermal control polarity wrong");
  a_feed_pulse_once: assert property (
    O_DOG_FEED && !I_DOG_COUNT_WRITE && !regs_clr |=>
    !O_DOG_FEED && feed_reg)
    else $error("feed pulse longer than a cycle");
  a_soft_reset_defaults: assert property (
    wr_ctrl && bus_wdata[charger_regs_pkg::CB_RSTOTH] ##1 1'b1 |=>
    ucfg2_reg == charger_regs_pkg::UCFG2_RST &&
    ucfg1_reg == charger_regs_pkg::UCFG1_RST && ctrl_reg == 16'h0000)
    else $error("soft reset missed defaults");
  a_irq_start: assert property (
    irq_event |=> !O_IRQ_OEN &&
    irq_cnt == charger_regs_pkg::IRQ_CNT_W'(IRQ_CYC))
    else $error("irq pulse not started");
endmodule // charger_pmic_status_control_regs
`default_nettype wire

// file: charger_regs_pkg.sv
// constants, field layout and types shared by the register bank files
`default_nettype none
package charger_regs_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [1:0] FUNC_TAG = 2'b10;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  localparam logic [4:0] ADR_FAULT = 5'h00;
  localparam logic [4:0] ADR_STAT1 = 5'h01;
  localparam logic [4:0] ADR_STAT2 = 5'h02;
  localparam logic [4:0] ADR_CTRL = 5'h03;
  localparam logic [4:0] ADR_UCFG1 = 5'h04;
  localparam logic [4:0] ADR_UCFG2 = 5'h05;

  localparam int FB_ACK = 15;
  localparam int FB_DOG = 11;
  localparam int FB_OC = 10;
  localparam int FB_OV = 9;
  localparam int FB_TEMP = 0;
  localparam logic [15:0] FAULT_CLR_ALL_MASK = 16'h31fe;
  localparam logic [15:0] FAULT_USED_MASK = 16'hbfff;
  localparam logic [15:0] FAULT_RST = 16'h0000;
  localparam logic [15:0] ST1_EVT_MASK = 16'h00de;

  localparam int CB_THERM = 14;
  localparam int CB_FEED = 13;
  localparam int CB_CONV = 11;
  localparam int CB_CLRALL = 10;
  localparam int CB_RSTALL = 9;
  localparam int CB_RSTOTH = 8;
  localparam int CB_CLK = 6;
  localparam int CB_BOOST = 4;
  localparam int CB_CHG = 3;
  localparam int CB_LSW = 2;
  localparam int CB_RSW = 1;
  localparam int CB_SLEEP = 0;
  localparam logic [15:0] CTRL_KEEP_MASK = 16'h48df;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  localparam int U1_LED = 4;
  localparam int U1_BOOST = 2;
  localparam int U1_TRIM = 0;
  localparam logic [15:0] UCFG1_MASK = 16'h003f;
  localparam logic [15:0] UCFG1_RST = 16'h002a;
  localparam int U2_VOUT = 10;
  localparam int U2_INLIM = 8;
  localparam int U2_PCHI = 6;
  localparam int U2_PCHV = 4;
  localparam int U2_CC = 2;
  localparam int U2_RCH = 0;
  localparam logic [15:0] UCFG2_MASK = 16'h1fff;
  localparam logic [15:0] UCFG2_RST = 16'h1151;

  localparam int CLK_MHZ = 25;
  localparam int IRQ_PULSE_US = 8000;
  localparam int IRQ_CYC = IRQ_PULSE_US * CLK_MHZ;
  localparam int IRQ_CNT_W = 18;

  typedef enum logic [2:0] {PH_IDLE, PH_FUNC, PH_HI, PH_LO, PH_SKIP} phase_t;
endpackage
`default_nettype wire

// file: serial_frame_slave.sv
// two-wire slave: function byte, then high and low data bytes
`default_nettype none
module serial_frame_slave (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_bus_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oen,
  output logic o_wr,
  output logic [4:0] o_addr,
  output logic [15:0] o_wdata,
  input wire logic [15:0] i_rdata,
  output logic o_nack
);
  charger_regs_pkg::phase_t phase;
  logic scl_q, sda_q, rw, func_ok, nack_seen, sda_low;
  logic [3:0] cnt;
  logic [7:0] sh, hi;
  logic [15:0] tx;
  logic rise, fall, start, stop, busy, rd_data;

  assign rise = i_scl & ~scl_q;
  assign fall = ~i_scl & scl_q;
  assign start = scl_q & i_scl & sda_q & ~i_sda;
  assign stop = scl_q & i_scl & ~sda_q & i_sda;
  assign busy = (phase != charger_regs_pkg::PH_IDLE);
  assign rd_data = rw & (phase == charger_regs_pkg::PH_HI ||
                         phase == charger_regs_pkg::PH_LO);
  assign o_sda_oen = ~sda_low;
  assign o_wdata = {hi, sh};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // frame sequencing: one register access per start condition
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= charger_regs_pkg::PH_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      hi <= 8'h00;
      tx <= 16'h0000;
      o_addr <= 5'h00;
      rw <= 1'b0;
      func_ok <= 1'b0;
      nack_seen <= 1'b0;
    end else if (i_bus_rst || stop) begin
      phase <= charger_regs_pkg::PH_IDLE;
      cnt <= 4'h0;
    end else if (start) begin
      phase <= charger_regs_pkg::PH_FUNC;
      // the scl fall that ends the start is no data bit: it wraps this to 0
      cnt <= 4'hf;
      nack_seen <= 1'b0;
    end else if (rise && busy) begin
      if (cnt != charger_regs_pkg::ACK_SLOT) begin
        sh <= {sh[6:0], i_sda};
      end else if (phase == charger_regs_pkg::PH_HI && rw && i_sda) begin
        nack_seen <= 1'b1;
      end
    end else if (fall && busy) begin
      if (rd_data && cnt != charger_regs_pkg::ACK_SLOT) begin
        tx <= {tx[14:0], 1'b0};
      end
      if (cnt == charger_regs_pkg::LAST_BIT) begin
        if (phase == charger_regs_pkg::PH_FUNC) begin
          o_addr <= sh[5:1];
          rw <= sh[0];
          func_ok <= (sh[7:6] == charger_regs_pkg::FUNC_TAG);
        end
        if (phase == charger_regs_pkg::PH_HI) begin
          hi <= sh;
        end
      end
      if (cnt == charger_regs_pkg::ACK_SLOT) begin
        cnt <= 4'h0;
        unique case (phase)
          charger_regs_pkg::PH_FUNC: begin
            phase <= func_ok ? charger_regs_pkg::PH_HI
                             : charger_regs_pkg::PH_SKIP;
            tx <= i_rdata;
          end
          charger_regs_pkg::PH_HI: begin
            phase <= (rw && nack_seen) ? charger_regs_pkg::PH_SKIP
                                       : charger_regs_pkg::PH_LO;
          end
          default: phase <= charger_regs_pkg::PH_SKIP;
        endcase
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end

  // pin drive is taken only on falling scl so data is stable while high; bus reset, start, stop or idle release it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sda_low <= 1'b0;
    end else if (i_bus_rst || stop || start || !busy) begin
      sda_low <= 1'b0;
    end else if (fall) begin
      if (cnt == charger_regs_pkg::LAST_BIT) begin
        sda_low <= (phase == charger_regs_pkg::PH_FUNC &&
                    sh[7:6] == charger_regs_pkg::FUNC_TAG) ||
                   (!rw && (phase == charger_regs_pkg::PH_HI ||
                            phase == charger_regs_pkg::PH_LO));
      end else if (cnt == charger_regs_pkg::ACK_SLOT) begin
        if (phase == charger_regs_pkg::PH_FUNC) begin
          sda_low <= rw && func_ok && !i_rdata[15];
        end else begin
          sda_low <= rw && phase == charger_regs_pkg::PH_HI &&
                     !nack_seen && !tx[15];
        end
      end else begin
        sda_low <= rd_data && !tx[14];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wr <= 1'b0;
      o_nack <= 1'b0;
    end else begin
      o_wr <= fall && !i_bus_rst && cnt == charger_regs_pkg::LAST_BIT &&
              phase == charger_regs_pkg::PH_LO && !rw;
      o_nack <= rise && !i_bus_rst && cnt == charger_regs_pkg::ACK_SLOT &&
                phase == charger_regs_pkg::PH_HI && rw && i_sda;
    end
  end
endmodule // serial_frame_slave
`default_nettype wire

// file: host_bus.sv
// host bus master model that frames register accesses
`default_nettype none
module host_bus (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic o_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic r;
  initial begin
    o_scl = 1;
    o_sda = 1;
    o_done = 0;
  end
  // sda moves mid-low so the slave never mistakes it for start or stop
  task automatic bit1(input logic b);
    repeat (2) @(posedge i_clk);
    #1 o_sda = b;
    repeat (3) @(posedge i_clk);
    #1 o_scl = 1;
    repeat (4) @(posedge i_clk);
    r = i_sda;
    #1 o_scl = 0;
  endtask
  task automatic xfer(input logic [7:0] fn, input logic [15:0] wd,
                      input logic nk);
    #1 o_sda = 0;
    repeat (4) @(posedge i_clk);
    #1 o_scl = 0;
    for (int i = 23; i >= 0; i--) begin
      bit1(i > 15 ? fn[i-16] : (fn[0] | wd[i]));
      if (i < 16) o_rdata[i] = r;
      if (i % 8 == 0) begin
        bit1(!(fn[0] && i == 8 && !nk));
        if (i == 16) o_ack = r;
        if (fn[0] && i == 8 && nk) break;
      end
    end
    // stop: sda low under low scl, raise scl, then release sda
    repeat (2) @(posedge i_clk);
    #1 o_sda = 0;
    repeat (3) @(posedge i_clk);
    #1 o_scl = 1;
    repeat (4) @(posedge i_clk);
    #1 o_sda = 1;
    repeat (4) @(posedge i_clk);
    if (fn[0] && !nk) begin
      #1 o_done = 1;
      @(posedge i_clk);
      #1 o_done = 0;
    end
  endtask
endmodule // host_bus
`default_nettype wire

// file: charger_pmic_status_control_regs_test.sv
// self-checking bench for the charger register bank
`default_nettype none
module charger_pmic_status_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_CLK, I_NRST, dw, done, ack, scl, hs, sdo, oen, irqn, feed, crst;
  logic [13:0] f;
  logic [15:0] s1, s2, v, rdat;
  wire [15:0] c;
  wire [5:0] u1;
  wire [12:0] u2;
  wire sda = hs & (oen | sdo);
  string nq[$];
  logic [15:0] eq[$];
  int comparisons = 0;
  int n_mismatch = 0;
  logic [15:0] n_feed = 16'h0000;
  logic [15:0] n_crst = 16'h0000;
  host_bus hb (.i_clk(I_CLK), .i_sda(sda), .o_scl(scl), .o_sda(hs),
    .o_done(done), .o_rdata(rdat), .o_ack(ack));
  charger_pmic_status_control_regs #(.IRQ_CYC(20)) dut_u (.I_CLK(I_CLK),
    .I_NRST(I_NRST), .I_SCL(scl), .I_SDA(sda), .O_SDA(sdo),
    .O_SDA_OEN(oen), .O_IRQ(), .O_IRQ_OEN(irqn), .I_DOG_COUNT_WRITE(dw),
    .I_PRECHARGE_TIMEOUT_FAULT(f[13]), .I_CHARGE_TIMEOUT_FAULT(f[12]),
    .I_DOG_TIMEOUT_FAULT(f[11]), .I_INPUT_OVERCURRENT_FAULT(f[10]),
    .I_INPUT_OVERVOLTAGE_FAULT(f[9]), .I_RIGHT_BUD_UNDERVOLTAGE_FAULT(f[8]),
    .I_LEFT_BUD_UNDERVOLTAGE_FAULT(f[7]), .I_SYS_RAIL_OVERVOLTAGE_FAULT(f[6]),
    .I_SYS_RAIL_UNDERVOLTAGE_FAULT(f[5]), .I_THERMISTOR_HOT_FAULT(f[4]),
    .I_THERMISTOR_COLD_FAULT(f[3]), .I_BATTERY_OVERVOLTAGE_FAULT(f[2]),
    .I_BATTERY_UNDERVOLTAGE_FAULT(f[1]), .I_OVER_TEMPERATURE_FAULT(f[0]),
    .I_PRECHARGE_ON_FLAG(s1[15]), .I_INPUT_SUPPLY_ON_FLAG(s1[14]),
    .I_INPUT_OV_DETECT_ON_FLAG(s1[13]), .I_BELOW_PRECHARGE_LEVEL_FLAG(s1[12]),
    .I_BELOW_RECHARGE_LEVEL_FLAG(s1[11]), .I_LEFT_SWITCH_ON_FLAG(s1[10]),
    .I_RIGHT_SWITCH_ON_FLAG(s1[9]), .I_INPUT_ATTACHED_FLAG(s1[7]),
    .I_CHARGE_DONE_FLAG(s1[6]), .I_CC_PHASE_DONE_FLAG(s1[5]),
    .I_LEFT_BUD_PRESENT_FLAG(s1[4]), .I_RIGHT_BUD_PRESENT_FLAG(s1[3]),
    .I_LEFT_LIGHT_LOAD_FLAG(s1[2]), .I_RIGHT_LIGHT_LOAD_FLAG(s1[1]),
    .I_BOOST_ON_FLAG(s1[0]), .I_LEFT_UV_DETECT_ON_FLAG(s2[7]),
    .I_RIGHT_UV_DETECT_ON_FLAG(s2[6]), .I_RECHARGE_COMPARATOR_ON_FLAG(s2[5]),
    .I_BATTERY_OV_DETECT_ON_FLAG(s2[4]), .I_CHARGING_ON_FLAG(s2[0]),
    .I_PRECHARGE_COMPARATOR_ON_FLAG(s2[1]), .O_DOG_FEED(feed),
    .O_CHIP_RESET(crst),
    .O_THERMAL_REGULATION_OFF(c[14]), .O_CONVERTER_ON(c[11]),
    .O_CONVERTER_CLOCK_SELECT(c[7:6]), .O_BOOST_ON(c[4]),
    .O_CHARGING_ON(c[3]), .O_LEFT_SWITCH_ON(c[2]), .O_SLEEP_ON(c[0]),
    .O_RIGHT_SWITCH_ON(c[1]), .O_INDICATOR_DRIVE_CURRENT(u1[5:4]),
    .O_BOOST_CURRENT_THRESHOLD(u1[3:2]), .O_LIGHT_LOAD_TRIM(u1[1:0]),
    .O_BOOST_VOLTAGE_SELECT(u2[12:10]), .O_INPUT_LIMIT_TRIM(u2[9:8]),
    .O_PRECHARGE_CURRENT_SELECT(u2[7:6]), .O_CC_CURRENT_SCALE(u2[3:2]),
    .O_PRECHARGE_END_VOLTAGE(u2[5:4]), .O_RECHARGE_THRESHOLD_SELECT(u2[1:0]));
  task automatic chk(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    hb.xfer({2'b10, a, 1'b0}, d, 1'b0);
  endtask
  task automatic rd(input string n, input logic [4:0] a, input logic [15:0] e);
    nq.push_back(n);
    eq.push_back(e);
    hb.xfer({2'b10, a, 1'b1}, 16'h0000, 1'b0);
  endtask
  task automatic results();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge done) chk(nq.pop_front(), eq.pop_front(), rdat);
  // one-cycle pulses are counted so their number can be compared
  always @(posedge I_CLK) begin
    n_feed <= n_feed + {15'h0000, feed};
    n_crst <= n_crst + {15'h0000, crst};
  end
  initial begin
    I_CLK = 0;
    forever #20 I_CLK = ~I_CLK;
  end
  initial begin
    #1000000 n_mismatch++;
    results();
  end
  initial begin
    {I_NRST, dw, f, s1, s2} = '0;
    void'($urandom(79));
    repeat (12) @(posedge I_CLK);
    #1 I_NRST = 1;
    repeat (3) @(posedge I_CLK);
    rd("ucfg1", 5'h04, 16'h002a);
    rd("ucfg2", 5'h05, 16'h1151);
    v = 16'($urandom) & 16'h48df;
    wr(5'h03, v);
    rd("ctrl", 5'h03, v);
    chk("ctrl_pins", v, c & 16'h48df);
    v = 16'($urandom);
    wr(5'h05, v);
    rd("ucfg2", 5'h05, v & 16'h1fff);
    chk("ucfg2_pins", v & 16'h1fff, {3'b000, u2});
    #1 f = 14'h3fff;
    @(posedge I_CLK);
    #1 f = 0;
    repeat (3) @(posedge I_CLK);
    chk("irq_oen", 16'h0000, {15'h0000, irqn});
    rd("fault", 5'h00, 16'h3fff);
    chk("irq_release", 16'h0001, {15'h0000, irqn});
    wr(5'h03, 16'h0400);
    rd("fault", 5'h00, 16'h0e01);
    wr(5'h03, 16'h2000);
    chk("dog_feed", 16'h0001, n_feed);
    rd("fault", 5'h00, 16'h0601);
    rd("feed_set", 5'h03, 16'h2000);
    #1 f[11] = 1;
    @(posedge I_CLK);
    #1 {f[11], dw} = 2'b01;
    @(posedge I_CLK);
    #1 dw = 0;
    rd("feed_cleared", 5'h03, 16'h0000);
    rd("fault", 5'h00, 16'h0601);
    hb.xfer({2'b10, 5'h00, 1'b1}, 16'h0000, 1'b1);
    rd("fault", 5'h00, 16'h8601);
    wr(5'h00, 16'h8000);
    rd("fault", 5'h00, 16'h0601);
    {s1, s2} = $urandom;
    rd("stat1", 5'h01, s1 & 16'hfeff);
    rd("stat2", 5'h02, s2 & 16'h00f3);
    rd("unmapped", 5'h1f, 16'h0000);
    hb.xfer(8'h40, 16'h0000, 1'b0);
    chk("func_nack", 16'h0001, {15'h0000, ack});
    for (int b = 8; b < 10; b++) begin
      wr(5'h04, 16'h0015);
      wr(5'h03, 16'h0001 << b);
      rd("soft_reset", 5'h04, 16'h002a);
    end
    rd("fault_after_reset", 5'h00, 16'h0000);
    chk("chip_reset", 16'h0002, n_crst);
    results();
  end
endmodule // charger_pmic_status_control_regs_test
`default_nettype wire
